// >>> bench/ssjh_stage_model.sv
// behavioural servo stage: encoder counts while driven, limit switch at a fixed count
// assumes motor outputs are registered on the rising edge of clk_i
module ssjh_stage_model #(
  parameter int LIM_POS = 40
) (
  input  wire logic clk_i,
  input  wire logic motor_run_i,
  input  wire logic motor_dir_i,
  output logic      enc_step_o,
  output logic      enc_dir_o,
  output logic      limit_sw_o,
  output int        pos_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] tick_r = 2'h0;
  initial begin
    pos_o = 0;
    enc_step_o = 1'b0;
    enc_dir_o = 1'b1;
  end
  // one count every fourth cycle: count and run command are both registered, so a faster
  // stage would overshoot every target and hunt around it; idle direction line toggles
  always @(posedge clk_i) begin
    tick_r <= tick_r + 2'h1;
    enc_step_o <= motor_run_i && tick_r == 2'h3;
    enc_dir_o <= motor_run_i ? motor_dir_i : ~enc_dir_o;
    if (motor_run_i && tick_r == 2'h3)
      pos_o <= motor_dir_i ? pos_o + 1 : pos_o - 1;
  end
  assign limit_sw_o = (pos_o >= LIM_POS);
endmodule

// >>> bench/tb.sv
// self-checking bench for the stage sequencer: speed digits, jog, zero, bounds, moves, homing
// assumes the stage model stands in for motor and encoder; also stepping, program, reset
module tb;
  import ssjh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic sel; logic [SPD_W-1:0] dig; logic [BAR_W-1:0] bar;} ssjh_row_s;
  logic clk_i = 1'b0, rstn_i = 1'b0, jog_forward_key_i = 1'b0, jog_backward_key_i = 1'b0;
  logic mod_key_i = 1'b0, home_key_i = 1'b0, abort_key_i = 1'b0, confirm_key_i = 1'b0;
  logic step_mode_i = 1'b0, jog_speed_set_i = 1'b0, fast_speed_set_i = 1'b0;
  logic zero_key_i = 1'b0, offset_load_i = 1'b0, backward_soft_bound_key_i = 1'b0;
  logic forward_soft_bound_key_i = 1'b0, abs_go_i = 1'b0, rel_go_i = 1'b0, run_key_i = 1'b0;
  logic recall_key_i = 1'b0, store_key_i = 1'b0, store_seq_i = 1'b0, store_insert_i = 1'b0;
  logic edit_we_i = 1'b0, edit_rel_i = 1'b0, edit_exec_i = 1'b0, edit_wait_i = 1'b0;
  logic [SPD_W-1:0]  speed_digit_i = 4'h1, move_speed_i = 4'h4, motor_speed_o;
  logic [POS_W-1:0]  offset_i = 32'h0, move_value_i = 32'h0, edit_coord_i = 32'h0, position_o;
  logic [IDX_W-1:0]  loc_index_i = 7'h00, cur_index_o;
  logic [SEC_W-1:0]  edit_pause_i = 8'h00;
  logic [LOOP_W-1:0] edit_loop_i = 8'h00;
  logic [BAR_W-1:0]  speed_bar_o;
  logic limit_sw_i, enc_step_i, enc_dir_i, motor_run_o, motor_dir_o, busy_o, await_confirm_o;
  int mpos, base, off, err_count = 0, compares = 0, cyc = 0;
  ssjh_row_s rows [6] = '{'{0, 4'h1, 9'h001}, '{0, 4'h9, 9'h1ff}, '{1, 4'h7, 9'h07f},
                          '{1, 4'h0, 9'h07f}, '{0, 4'h2, 9'h003}, '{0, 4'hc, 9'h003}};
  ssjh_sequencer #(.SEC_CYCLES(10), .STEP_CYCLES(16)) DUT (.*);
  ssjh_stage_model STAGE (.clk_i(clk_i), .motor_run_i(motor_run_o), .motor_dir_i(motor_dir_o),
    .enc_step_o(enc_step_i), .enc_dir_o(enc_dir_i), .limit_sw_o(limit_sw_i), .pos_o(mpos));
  always #10 clk_i = ~clk_i;
  task automatic check(input string what, input logic [POS_W-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cycles(1);
    s = 1'b0;
    cycles(2);
  endtask
  // busy lags the state by one cycle, so settle first, then wait with a bound
  task automatic settle();
    cycles(3);
    for (int k = 0; k < 3000 && busy_o !== 1'b0; k++)
      cycles(1);
    cycles(4);
  endtask
  task automatic chk_pos(input string what);
    check(what, position_o, POS_W'(mpos - base + off));
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    cycles(1);
    check("run at reset", motor_run_o, 1'b0);
    check("dir at reset", motor_dir_o, 1'b1);
    check("speed at reset", motor_speed_o, JOG_SPD_RST);
    check("bar at reset", {speed_bar_o, cur_index_o, busy_o, await_confirm_o}, 32'h0);
    check("position at reset", position_o, 32'h0);
    cycles(2);
    rstn_i = 1'b1;
    base = 0;
    off = 0;
    foreach (rows[i]) begin
      speed_digit_i = rows[i].dig;
      if (rows[i].sel) pulse(fast_speed_set_i);
      else pulse(jog_speed_set_i);
      check("speed bar", speed_bar_o, rows[i].bar);
    end
    $display("digit table done");
    jog_forward_key_i = 1'b1;
    cycles(4);
    check("fwd jog", {motor_run_o, motor_dir_o, motor_speed_o}, 6'h32);
    mod_key_i = 1'b1;
    cycles(3);
    check("fast jog speed", motor_speed_o, 4'h7);
    {mod_key_i, jog_forward_key_i} = 2'b00;
    settle();
    chk_pos("pos after fwd");
    jog_backward_key_i = 1'b1;
    cycles(20);
    check("bwd jog dir", {motor_run_o, motor_dir_o}, 2'b10);
    jog_backward_key_i = 1'b0;
    settle();
    chk_pos("pos after bwd");
    pulse(zero_key_i);
    base = mpos;
    check("zeroed", position_o, 32'h0);
    offset_i = 32'h64;
    off = 100;
    pulse(offset_load_i);
    chk_pos("offset");
    pulse(forward_soft_bound_key_i);
    jog_forward_key_i = 1'b1;
    cycles(6);
    check("stop at fwd bound", motor_run_o, 1'b0);
    jog_forward_key_i = 1'b0;
    cycles(2);
    move_value_i = 32'hffffffec;
    pulse(abs_go_i);
    check("abs move", {motor_run_o, motor_dir_o, motor_speed_o}, 6'h24);
    settle();
    chk_pos("abs arrival");
    pulse(backward_soft_bound_key_i);
    jog_backward_key_i = 1'b1;
    cycles(6);
    check("stop at bwd bound", motor_run_o, 1'b0);
    jog_backward_key_i = 1'b0;
    cycles(2);
    move_value_i = 32'hfffffc18;
    pulse(abs_go_i);
    check("bwd clamp", motor_run_o, 1'b0);
    move_value_i = 32'h50;
    pulse(abs_go_i);
    settle();
    check("fwd clamp", position_o, 32'h64);
    move_value_i = 32'hfffffffb;
    pulse(rel_go_i);
    settle();
    check("rel move", position_o, 32'h5f);
    {step_mode_i, jog_backward_key_i} = 2'b11;
    cycles(16);
    jog_backward_key_i = 1'b0;
    settle();
    check("one step", position_o, 32'h5d);
    $display("jog and move tests done");
    loc_index_i = 7'h02;
    pulse(store_key_i);
    {edit_coord_i, edit_rel_i, edit_exec_i, edit_pause_i, edit_loop_i} =
      {32'hfffffffd, 2'b11, 8'h01, 8'h01};
    loc_index_i = 7'h00;
    pulse(edit_we_i);
    {edit_coord_i, edit_wait_i, edit_loop_i, loc_index_i} = {32'h0, 1'b1, 8'h00, 7'h01};
    pulse(edit_we_i);
    pulse(run_key_i);
    for (int k = 0; k < 500 && await_confirm_o !== 1'b1; k++)
      cycles(1);
    check("wait reached", {await_confirm_o, cur_index_o}, 8'h81);
    check("loop passes", position_o, 32'h57);
    pulse(confirm_key_i);
    settle();
    check("stored location", position_o, 32'h5d);
    check("program end", cur_index_o, 7'h63);
    loc_index_i = 7'h04;
    pulse(recall_key_i);
    store_seq_i = 1'b1;
    pulse(store_key_i);
    check("sequential index", cur_index_o, 7'h05);
    store_seq_i = 1'b0;
    {jog_backward_key_i, mod_key_i} = 2'b11;
    cycles(4);
    check("shift in step mode", {motor_run_o, motor_dir_o, motor_speed_o}, 6'h27);
    mod_key_i = 1'b0;
    cycles(3);
    check("back to stepping", motor_speed_o, 4'h2);
    {step_mode_i, jog_backward_key_i} = 2'b00;
    settle();
    pulse(run_key_i);
    settle();
    check("sequential store", position_o, 32'h5d);
    move_value_i = 32'hffffffec;
    pulse(abs_go_i);
    pulse(abort_key_i);
    check("abort move", {busy_o, motor_run_o, cur_index_o}, 9'h063);
    $display("program tests done");
    pulse(abs_go_i);
    rstn_i = 1'b0;
    cycles(1);
    check("mid-run reset", {motor_run_o, motor_dir_o, busy_o, motor_speed_o}, 7'h23);
    rstn_i = 1'b1;
    cycles(2);
    check("after reset", {motor_run_o, busy_o, motor_speed_o}, 6'h03);
    check("position after reset", position_o, 32'h0);
    check("index after reset", {speed_bar_o, cur_index_o, await_confirm_o}, 17'h0);
    $display("reset test done");
    {home_key_i, mod_key_i} = 2'b11;
    cycles(1);
    {home_key_i, mod_key_i} = 2'b00;
    settle();
    check("latched home end", {busy_o, motor_run_o, limit_sw_i}, 3'b001);
    home_key_i = 1'b1;
    cycles(4);
    check("held home moving", motor_run_o, 1'b1);
    home_key_i = 1'b0;
    cycles(3);
    check("home released", motor_run_o, 1'b0);
    settle();
    {home_key_i, mod_key_i} = 2'b11;
    cycles(4);
    {home_key_i, mod_key_i} = 2'b00;
    pulse(abort_key_i);
    check("abort homing", {busy_o, motor_run_o}, 2'b00);
    $display("homing tests done");
    close_out();
  end
endmodule

// >>> hdl/ssjh_pkg.sv
// constants and types shared by the stage jog/home sequencer
// assumes a single 50 MHz clock domain and keypad levels already debounced
package ssjh_pkg;
  localparam int POS_W          = 32;
  localparam int SPD_W          = 4;
  localparam int IDX_W          = 7;
  localparam int DEPTH          = 100;
  localparam int SEC_W          = 8;
  localparam int LOOP_W         = 8;
  localparam int BAR_W          = 9;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int SEC_NS         = 1_000_000_000;
  localparam int SEC_CYC        = SEC_NS / CLK_PERIOD_NS;
  localparam int STEP_PERIOD_US = 10_000;
  localparam int STEP_CYC       = STEP_PERIOD_US * 1000 / CLK_PERIOD_NS;

  localparam logic [SPD_W-1:0]  SPD_MIN       = 4'h1;
  localparam logic [SPD_W-1:0]  SPD_MAX       = 4'h9;
  localparam logic [SPD_W-1:0]  HOME_SLOW_SPD = 4'h1;
  localparam logic [SPD_W-1:0]  JOG_SPD_RST   = 4'h3;
  localparam logic [SPD_W-1:0]  FAST_SPD_RST  = 4'h9;
  localparam logic [LOOP_W-1:0] LOOP_RST      = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_JOG,
    ST_HOME_FIND,
    ST_HOME_BACK,
    ST_HOME_CREEP,
    ST_MOVE,
    ST_PAUSE,
    ST_WAIT,
    ST_LOOP,
    ST_SEEK
  } ssjh_state_e;
endpackage

// >>> hdl/ssjh_sequencer.sv
// single-axis servo stage sequencer: jog, homing, soft bounds, moves, stored program
// assumes keypad strobes are one-cycle pulses and encoder steps are synchronous pulses
module ssjh_sequencer
  import ssjh_pkg::*;
#(
  parameter int LOCS        = ssjh_pkg::DEPTH,
  parameter int SEC_CYCLES  = ssjh_pkg::SEC_CYC,
  parameter int STEP_CYCLES = ssjh_pkg::STEP_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        jog_forward_key_i,
  input  wire logic                        jog_backward_key_i,
  input  wire logic                        mod_key_i,
  input  wire logic                        home_key_i,
  input  wire logic                        abort_key_i,
  input  wire logic                        confirm_key_i,
  input  wire logic                        limit_sw_i,
  input  wire logic                        enc_step_i,
  input  wire logic                        enc_dir_i,
  input  wire logic                        step_mode_i,
  input  wire logic [ssjh_pkg::SPD_W-1:0]  speed_digit_i,
  input  wire logic                        jog_speed_set_i,
  input  wire logic                        fast_speed_set_i,
  input  wire logic                        zero_key_i,
  input  wire logic                        offset_load_i,
  input  wire logic [ssjh_pkg::POS_W-1:0]  offset_i,
  input  wire logic                        backward_soft_bound_key_i,
  input  wire logic                        forward_soft_bound_key_i,
  input  wire logic                        abs_go_i,
  input  wire logic                        rel_go_i,
  input  wire logic [ssjh_pkg::POS_W-1:0]  move_value_i,
  input  wire logic [ssjh_pkg::SPD_W-1:0]  move_speed_i,
  input  wire logic                        run_key_i,
  input  wire logic                        recall_key_i,
  input  wire logic                        store_key_i,
  input  wire logic                        store_seq_i,
  input  wire logic                        store_insert_i,
  input  wire logic [ssjh_pkg::IDX_W-1:0]  loc_index_i,
  input  wire logic                        edit_we_i,
  input  wire logic [ssjh_pkg::POS_W-1:0]  edit_coord_i,
  input  wire logic                        edit_rel_i,
  input  wire logic                        edit_exec_i,
  input  wire logic                        edit_wait_i,
  input  wire logic [ssjh_pkg::SEC_W-1:0]  edit_pause_i,
  input  wire logic [ssjh_pkg::LOOP_W-1:0] edit_loop_i,
  output logic                             motor_run_o,
  output logic                             motor_dir_o,
  output logic [ssjh_pkg::SPD_W-1:0]       motor_speed_o,
  output logic [ssjh_pkg::POS_W-1:0]       position_o,
  output logic [ssjh_pkg::BAR_W-1:0]       speed_bar_o,
  output logic [ssjh_pkg::IDX_W-1:0]       cur_index_o,
  output logic                             busy_o,
  output logic                             await_confirm_o
);
  import ssjh_pkg::*;

  if (LOCS < 2 || LOCS > (1 << IDX_W) || SEC_CYCLES < 1 || STEP_CYCLES < 1) begin : g_chk
    $error("ssjh_sequencer: unsupported parameter value");
  end

  localparam logic [IDX_W-1:0] LAST = IDX_W'(LOCS - 1);

  ssjh_state_e              state_r;
  logic signed [POS_W-1:0]  pos_cnt_r;
  logic signed [POS_W-1:0]  offset_r;
  logic signed [POS_W-1:0]  target_r;
  logic signed [POS_W-1:0]  back_bound_r;
  logic signed [POS_W-1:0]  fwd_bound_r;
  logic                     back_valid_r;
  logic                     fwd_valid_r;
  logic [SPD_W-1:0]         jog_speed_r;
  logic [SPD_W-1:0]         fast_speed_r;
  logic                     home_latch_r;
  logic                     home_prev_r;
  logic                     run_r;
  logic [IDX_W-1:0]         cur_idx_r;
  logic [LOOP_W-1:0]        pass_r;
  logic [31:0]              tmr_r;
  logic [SEC_W-1:0]         sec_left_r;

  logic signed [POS_W-1:0]  mem_coord_r [LOCS];
  logic                     mem_rel_r   [LOCS];
  logic                     mem_exec_r  [LOCS];
  logic                     mem_wr_r    [LOCS];
  logic                     mem_wait_r  [LOCS];
  logic [SEC_W-1:0]         mem_pause_r [LOCS];
  logic [LOOP_W-1:0]        mem_loop_r  [LOCS];

  logic                     at_back;
  logic                     at_fwd;
  logic                     home_start;
  logic                     jog_any;
  logic                     store_fire;
  logic [IDX_W-1:0]         st_addr;
  logic signed [POS_W-1:0]  step_size;
  logic                     digit_ok;
  logic                     home_stop;
  logic                     run_nxt;
  logic                     dir_nxt;
  logic [SPD_W-1:0]         spd_nxt;

  function automatic logic signed [POS_W-1:0] clamp(input logic signed [POS_W-1:0] t);
    logic signed [POS_W-1:0] r;
    r = t;
    if (fwd_valid_r && r > fwd_bound_r)
      r = fwd_bound_r;
    if (back_valid_r && r < back_bound_r)
      r = back_bound_r;
    return r;
  endfunction

  assign at_back    = back_valid_r && pos_cnt_r <= back_bound_r;
  assign at_fwd     = fwd_valid_r && pos_cnt_r >= fwd_bound_r;
  assign jog_any    = jog_forward_key_i || jog_backward_key_i;
  assign home_start = home_key_i && !home_prev_r;
  assign home_stop  = abort_key_i || (!home_latch_r && !home_key_i);
  assign digit_ok   = speed_digit_i >= SPD_MIN && speed_digit_i <= SPD_MAX;
  assign step_size  = POS_W'(1) <<< (jog_speed_r - SPD_MIN);
  // store is the lowest-priority idle command so it never races a motion start
  assign store_fire = state_r == ST_IDLE && store_key_i && !home_start && !jog_any
                      && !abs_go_i && !rel_go_i && !run_key_i && !recall_key_i;
  assign st_addr    = !store_seq_i ? loc_index_i
                      : (cur_idx_r < LAST ? cur_idx_r + IDX_W'(1) : cur_idx_r);

  // sequencing: jog, homing, moves and program run
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r      <= ST_IDLE;
      target_r     <= '0;
      home_latch_r <= 1'b0;
      home_prev_r  <= 1'b0;
      run_r        <= 1'b0;
      cur_idx_r    <= '0;
      pass_r       <= '0;
      tmr_r        <= '0;
      sec_left_r   <= '0;
    end else begin
      home_prev_r <= home_key_i;
      case (state_r)
        ST_IDLE: begin
          if (home_start) begin
            state_r      <= ST_HOME_FIND;
            home_latch_r <= mod_key_i;
          end else if (jog_any) begin
            state_r  <= ST_JOG;
            tmr_r    <= '0;
            target_r <= pos_cnt_r;
          end else if (abs_go_i) begin
            target_r <= clamp(move_value_i);
            state_r  <= ST_MOVE;
          end else if (rel_go_i) begin
            target_r <= clamp(pos_cnt_r + move_value_i);
            state_r  <= ST_MOVE;
          end else if (run_key_i) begin
            run_r   <= 1'b1;
            pass_r  <= '0;
            state_r <= ST_SEEK;
          end else if (recall_key_i) begin
            if (loc_index_i <= LAST)
              cur_idx_r <= loc_index_i;
          end else if (store_fire && store_seq_i) begin
            cur_idx_r <= st_addr;
          end
        end
        ST_HOME_FIND: begin
          if (home_stop)
            state_r <= ST_IDLE;
          else if (limit_sw_i)
            state_r <= ST_HOME_BACK;
        end
        ST_HOME_BACK: begin
          if (home_stop)
            state_r <= ST_IDLE;
          else if (!limit_sw_i)
            state_r <= ST_HOME_CREEP;
        end
        ST_HOME_CREEP: begin
          if (home_stop || limit_sw_i)
            state_r <= ST_IDLE;
        end
        ST_JOG: begin
          if (!jog_any) begin
            state_r <= ST_IDLE;
          end else if (step_mode_i && !mod_key_i) begin
            if (tmr_r == '0) begin
              tmr_r    <= 32'(STEP_CYCLES - 1);
              target_r <= clamp(jog_forward_key_i ? pos_cnt_r + step_size
                                                  : pos_cnt_r - step_size);
            end else begin
              tmr_r <= tmr_r - 32'h1;
            end
          end else begin
            tmr_r    <= '0;
            target_r <= pos_cnt_r;
          end
        end
        ST_MOVE: begin
          if (abort_key_i) begin
            state_r <= ST_IDLE;
            run_r   <= 1'b0;
          end else if (pos_cnt_r == target_r) begin
            if (!run_r) begin
              state_r <= ST_IDLE;
            end else if (mem_wait_r[cur_idx_r]) begin
              state_r <= ST_WAIT;
            end else if (mem_pause_r[cur_idx_r] != '0) begin
              state_r    <= ST_PAUSE;
              tmr_r      <= 32'(SEC_CYCLES - 1);
              sec_left_r <= mem_pause_r[cur_idx_r];
            end else begin
              state_r <= ST_LOOP;
            end
          end
        end
        ST_PAUSE: begin
          if (abort_key_i) begin
            state_r <= ST_IDLE;
            run_r   <= 1'b0;
          end else if (tmr_r != '0) begin
            tmr_r <= tmr_r - 32'h1;
          end else if (sec_left_r == SEC_W'(1)) begin
            state_r <= ST_LOOP;
          end else begin
            sec_left_r <= sec_left_r - SEC_W'(1);
            tmr_r      <= 32'(SEC_CYCLES - 1);
          end
        end
        ST_WAIT: begin
          if (abort_key_i) begin
            state_r <= ST_IDLE;
            run_r   <= 1'b0;
          end else if (confirm_key_i) begin
            state_r <= ST_LOOP;
          end
        end
        ST_LOOP: begin
          if (pass_r < mem_loop_r[cur_idx_r]) begin
            pass_r  <= pass_r + LOOP_W'(1);
            state_r <= ST_SEEK;
          end else if (cur_idx_r == LAST) begin
            pass_r  <= '0;
            run_r   <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            pass_r    <= '0;
            cur_idx_r <= cur_idx_r + IDX_W'(1);
            state_r   <= ST_SEEK;
          end
        end
        ST_SEEK: begin
          if (abort_key_i) begin
            run_r   <= 1'b0;
            state_r <= ST_IDLE;
          end else if (mem_exec_r[cur_idx_r] && mem_wr_r[cur_idx_r]) begin
            target_r <= clamp(mem_rel_r[cur_idx_r] ? pos_cnt_r + mem_coord_r[cur_idx_r]
                                                   : mem_coord_r[cur_idx_r]);
            state_r  <= ST_MOVE;
          end else if (cur_idx_r == LAST) begin
            run_r   <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            cur_idx_r <= cur_idx_r + IDX_W'(1);
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // position counter, offset and soft bounds
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos_cnt_r    <= '0;
      offset_r     <= '0;
      back_bound_r <= '0;
      fwd_bound_r  <= '0;
      back_valid_r <= 1'b0;
      fwd_valid_r  <= 1'b0;
    end else begin
      if (zero_key_i) begin
        pos_cnt_r <= '0;
        offset_r  <= '0;
      end else begin
        if (enc_step_i)
          pos_cnt_r <= enc_dir_i ? pos_cnt_r + POS_W'(1) : pos_cnt_r - POS_W'(1);
        if (offset_load_i)
          offset_r <= offset_i;
      end
      if (backward_soft_bound_key_i) begin
        back_bound_r <= pos_cnt_r;
        back_valid_r <= 1'b1;
      end
      if (forward_soft_bound_key_i) begin
        fwd_bound_r <= pos_cnt_r;
        fwd_valid_r <= 1'b1;
      end
    end
  end

  // speed selection and symbol row
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      jog_speed_r  <= JOG_SPD_RST;
      fast_speed_r <= FAST_SPD_RST;
      speed_bar_o  <= '0;
    end else if (digit_ok && (jog_speed_set_i || fast_speed_set_i)) begin
      if (jog_speed_set_i)
        jog_speed_r <= speed_digit_i;
      else
        fast_speed_r <= speed_digit_i;
      speed_bar_o <= BAR_W'((1 << speed_digit_i) - 1);
    end
  end

  // location memory: store, insert-shift and field edit
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < LOCS; i++) begin
        mem_coord_r[i] <= '0;
        mem_rel_r[i]   <= 1'b0;
        mem_exec_r[i]  <= 1'b0;
        mem_wr_r[i]    <= 1'b0;
        mem_wait_r[i]  <= 1'b0;
        mem_pause_r[i] <= '0;
        mem_loop_r[i]  <= LOOP_RST;
      end
    end else if (store_fire && st_addr <= LAST) begin
      // shifting drops the content of the last location
      if (!store_seq_i && store_insert_i && mem_wr_r[st_addr]) begin
        for (int i = LOCS - 1; i > 0; i--) begin
          if (IDX_W'(i) > st_addr) begin
            mem_coord_r[i] <= mem_coord_r[i-1];
            mem_rel_r[i]   <= mem_rel_r[i-1];
            mem_exec_r[i]  <= mem_exec_r[i-1];
            mem_wr_r[i]    <= mem_wr_r[i-1];
            mem_wait_r[i]  <= mem_wait_r[i-1];
            mem_pause_r[i] <= mem_pause_r[i-1];
            mem_loop_r[i]  <= mem_loop_r[i-1];
          end
        end
      end
      mem_coord_r[st_addr] <= pos_cnt_r;
      mem_rel_r[st_addr]   <= 1'b0;
      mem_exec_r[st_addr]  <= 1'b1;
      mem_wr_r[st_addr]    <= 1'b1;
      mem_wait_r[st_addr]  <= 1'b0;
      mem_pause_r[st_addr] <= '0;
      mem_loop_r[st_addr]  <= LOOP_RST;
    end else if (edit_we_i && loc_index_i <= LAST) begin
      mem_coord_r[loc_index_i] <= edit_coord_i;
      mem_rel_r[loc_index_i]   <= edit_rel_i;
      mem_exec_r[loc_index_i]  <= edit_exec_i;
      mem_wr_r[loc_index_i]    <= 1'b1;
      mem_wait_r[loc_index_i]  <= edit_wait_i;
      mem_pause_r[loc_index_i] <= edit_wait_i ? '0 : edit_pause_i;
      mem_loop_r[loc_index_i]  <= edit_loop_i;
    end
  end

  // motor command; a target chase covers stepped jog and all moves
  always_comb begin
    run_nxt = pos_cnt_r != target_r;
    dir_nxt = target_r > pos_cnt_r;
    spd_nxt = jog_speed_r;
    case (state_r)
      ST_JOG: begin
        if (!(step_mode_i && !mod_key_i)) begin
          dir_nxt = jog_forward_key_i;
          spd_nxt = mod_key_i ? fast_speed_r : jog_speed_r;
          run_nxt = jog_forward_key_i ? !at_fwd : !at_back;
        end
      end
      ST_HOME_FIND: begin
        run_nxt = 1'b1;
        dir_nxt = 1'b1;
        spd_nxt = fast_speed_r;
      end
      ST_HOME_BACK: begin
        run_nxt = 1'b1;
        dir_nxt = 1'b0;
        spd_nxt = HOME_SLOW_SPD;
      end
      ST_HOME_CREEP: begin
        run_nxt = 1'b1;
        dir_nxt = 1'b1;
        spd_nxt = HOME_SLOW_SPD;
      end
      ST_MOVE: spd_nxt = move_speed_i;
      default: run_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      motor_run_o     <= 1'b0;
      motor_dir_o     <= 1'b1;
      motor_speed_o   <= JOG_SPD_RST;
      position_o      <= '0;
      cur_index_o     <= '0;
      busy_o          <= 1'b0;
      await_confirm_o <= 1'b0;
    end else begin
      motor_run_o     <= run_nxt;
      motor_dir_o     <= dir_nxt;
      motor_speed_o   <= spd_nxt;
      position_o      <= pos_cnt_r + offset_r;
      cur_index_o     <= cur_idx_r;
      busy_o          <= state_r != ST_IDLE;
      await_confirm_o <= state_r == ST_WAIT;
    end
  end

  chk_home_order:
  assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_r == ST_HOME_BACK && !home_stop && !limit_sw_i |=> state_r == ST_HOME_CREEP
      ##1 motor_run_o && motor_dir_o && motor_speed_o == HOME_SLOW_SPD)
    else $error("homing did not enter slow creep");
  chk_home_release:
  assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_r inside {ST_HOME_FIND, ST_HOME_BACK, ST_HOME_CREEP} && !home_latch_r
      && !home_key_i |=> state_r == ST_IDLE ##1 !motor_run_o)
    else $error("held homing kept running after release");
  chk_home_latch:
  assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_r == ST_IDLE && home_start && mod_key_i && !abort_key_i ##1 !home_key_i
      && !abort_key_i && !limit_sw_i |=> state_r == ST_HOME_FIND)
    else $error("latched homing dropped on release");
  chk_home_abort:
  assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_r inside {ST_HOME_FIND, ST_HOME_BACK, ST_HOME_CREEP} && abort_key_i
      |=> state_r == ST_IDLE)
    else $error("abort did not stop homing");
  chk_fast_jog:
  assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_r == ST_JOG && jog_any && mod_key_i |=> motor_speed_o == $past(fast_speed_r))
    else $error("modifier jog not at fast speed");
  chk_speed_bar:
  assert property (@(posedge clk_i) disable iff (!rstn_i)
    jog_speed_set_i && digit_ok |=> $countones(speed_bar_o) == int'($past(speed_digit_i))
      && jog_speed_r == $past(speed_digit_i))
    else $error("speed bar length differs from digit");
  chk_zero_clear:
  assert property (@(posedge clk_i) disable iff (!rstn_i)
    zero_key_i |=> pos_cnt_r == '0 ##1 position_o == $past(offset_r))
    else $error("zero did not clear the counter");
  chk_abort_move:
  assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_r == ST_MOVE && abort_key_i |=> state_r == ST_IDLE && $stable(cur_idx_r)
      ##1 !motor_run_o)
    else $error("abort did not halt move or moved index");
  chk_bound_grab:
  assert property (@(posedge clk_i) disable iff (!rstn_i)
    forward_soft_bound_key_i |=> fwd_valid_r && fwd_bound_r == $past(pos_cnt_r))
    else $error("forward bound not captured");
  chk_jog_bound:
  assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_r == ST_JOG && jog_backward_key_i && !jog_forward_key_i && at_back
      |=> !motor_run_o || motor_dir_o)
    else $error("jog ran past backward bound");
endmodule
